// ===== rtl/tcrt_pkg.sv
package tcrt_pkg;

    // register offsets on the plain register port
    localparam logic [3:0] TCRT_ADDR_BASIC_CTRL  = 4'h0;
    localparam logic [3:0] TCRT_ADDR_BASIC_MODE  = 4'h1;
    localparam logic [3:0] TCRT_ADDR_CNT0_LOW    = 4'h2;
    localparam logic [3:0] TCRT_ADDR_CNT0_HIGH   = 4'h3;
    localparam logic [3:0] TCRT_ADDR_CNT1_LOW    = 4'h4;
    localparam logic [3:0] TCRT_ADDR_CNT1_HIGH   = 4'h5;
    localparam logic [3:0] TCRT_ADDR_INT_EN      = 4'h6;
    // enhanced timer n sits at base + 4*n
    localparam logic [3:0] TCRT_ADDR_ENH_BASE    = 4'h8;
    localparam logic [1:0] TCRT_ENH_OFS_CTRL     = 2'h0;
    localparam logic [1:0] TCRT_ENH_OFS_CFG      = 2'h1;
    localparam logic [1:0] TCRT_ENH_OFS_RLD_LOW  = 2'h2;
    localparam logic [1:0] TCRT_ENH_OFS_RLD_HIGH = 2'h3;
    // enhanced count registers: offset unused, the counts are not mapped for reading
    localparam logic [3:0] TCRT_ADDR_ENH_CNT_BASE = 4'h0;

    // basic_timer_control fields (timer0 run/flag, timer1 run/flag)
    localparam int TCRT_CTRL_RUN0  = 4;
    localparam int TCRT_CTRL_FLAG0 = 5;
    localparam int TCRT_CTRL_RUN1  = 6;
    localparam int TCRT_CTRL_FLAG1 = 7;

    // basic_timer_mode_reg fields: timer0 in [3:0], timer1 in [7:4]
    localparam int TCRT_MODE_M_LSB  = 0;
    localparam int TCRT_MODE_GATE   = 3;
    localparam int TCRT_MODE_STRIDE = 4;

    // enhanced_timer_control fields
    localparam int TCRT_ECTL_CAPSEL = 0;
    localparam int TCRT_ECTL_CTSEL  = 1;
    localparam int TCRT_ECTL_RUN    = 2;
    localparam int TCRT_ECTL_DOWN   = 3;

    // enhanced_timer_config fields
    localparam int TCRT_ECFG_OE     = 1;
    localparam int TCRT_ECFG_TOGGLE = 2;

    localparam logic [7:0]  TCRT_RST_BYTE = 8'h00;
    localparam logic [15:0] TCRT_ALL_ONES = 16'hFFFF;
    localparam logic [7:0]  TCRT_BYTE_MAX = 8'hFF;

    typedef enum logic [1:0] {
        TCRT_MODE_13BIT  = 2'h0,
        TCRT_MODE_16BIT  = 2'h1,
        TCRT_MODE_RELOAD = 2'h2,
        TCRT_MODE_OFF    = 2'h3
    } tcrt_mode_e;

    typedef struct packed {
        logic       capsel;
        logic       ctsel;
        logic       run;
        logic       down;
        logic       oe;
        logic       level_wr;
        logic [7:0] level_data;
    } tcrt_enh_cfg_s;

endpackage

// ===== rtl/tcrt_enh_timer.sv
`timescale 1ns/100ps
// one enhanced 16-bit timer with reload pair and toggle output
module tcrt_enh_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    input  wire logic                 tick,
    input  wire tcrt_pkg::tcrt_enh_cfg_s cfg,
    input  wire logic [WIDTH-1:0]     reload_val,
    output logic [WIDTH-1:0]          count,
    output logic                      wrap,
    output logic                      toggle_level,
    output logic                      pin_out,
    output logic                      pin_oe_n
);
    logic counting;
    logic hit;

    // only reload timer mode with a running timer steps the count
    assign counting = cfg.run & tick & ~cfg.capsel & ~cfg.ctsel;
    // down: underflow on match with reload pair; up: on passing all ones
    assign hit  = cfg.down ? (count == reload_val) : (count == WIDTH'(tcrt_pkg::TCRT_ALL_ONES));
    assign wrap = counting & hit;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            count <= '0;
        end else if (counting) begin
            if (cfg.down) begin
                count <= hit ? WIDTH'(tcrt_pkg::TCRT_ALL_ONES) : count - 1'b1;
            end else begin
                count <= hit ? reload_val : count + 1'b1;
            end
        end
    end

    // written level wins so software can preset or hold the pin
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            toggle_level <= 1'b0;
        end else if (cfg.level_wr) begin
            toggle_level <= cfg.level_data[tcrt_pkg::TCRT_ECFG_TOGGLE];
        end else if (wrap) begin
            toggle_level <= ~toggle_level;
        end
    end

    assign pin_out  = toggle_level & cfg.oe;
    assign pin_oe_n = ~cfg.oe;
endmodule

// ===== rtl/tcrt_top.sv
`timescale 1ns/100ps
// Behaviour
// - mode 1 counts all 16 bits of low and high count registers, otherwise set up like the 13-bit mode.
// - auto-reload mode counts in the low register while the high register holds the reload value.
// - when the low count overflows at FF the overflow flag sets and the count loads from high instead of 00.
// - with the timer interrupt enabled a set overflow flag raises an interrupt request.
// - a reload never alters the reload register, so each period starts from the same value.
// - a basic timer counts only while run is set and either gate is 0 or the external input is low.
// - the second basic timer behaves the same with its own count, reload, flag and run bits.
// - only the enhanced timers toggle their pin, inverting it on each overflow or underflow.
// - counting down, an enhanced timer reloads all ones and underflows when it matches the reload pair.
// - counting up, an enhanced timer overflows past all ones and then loads the reload pair.
// - the toggle level reaches the pin only while the output enable config bit is 1.
// - setting the enhanced run bit starts the toggling when toggle output is configured.
// - config bit 2 reads the toggle level and a write forces the level.
// - square-wave frequency is the timer clock over twice (65536 minus the reload value).
module tcrt_top #(
    parameter int NUM_BASIC = 2,
    parameter int NUM_ENH   = 2
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        basic_tick,
    input  wire logic        enh_tick,
    input  wire logic [1:0]  ext_irq_input_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic [1:0]       timer_irq,
    output logic             toggle_pin_a,
    output logic             toggle_pin_a_oe_n,
    output logic             toggle_pin_b,
    output logic             toggle_pin_b_oe_n
);
    logic [7:0]  basic_timer_control;
    logic [7:0]  basic_timer_mode_reg;
    logic [7:0]  int_enable;
    logic [7:0]  count_low_reg         [NUM_BASIC];
    logic [7:0]  count_high_reload_reg [NUM_BASIC];
    logic [NUM_BASIC-1:0] basic_ovf;
    logic [NUM_BASIC-1:0] overflow_flag;

    logic [7:0]  enhanced_timer_control [NUM_ENH];
    logic [7:0]  enhanced_timer_config  [NUM_ENH];
    logic [7:0]  reload_pair_low        [NUM_ENH];
    logic [7:0]  reload_pair_high       [NUM_ENH];
    logic [NUM_ENH-1:0] enh_level;
    logic [NUM_ENH-1:0] enh_pin;
    logic [NUM_ENH-1:0] enh_pin_oe_n;

    logic [7:0]  next_rdata;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            basic_timer_mode_reg <= tcrt_pkg::TCRT_RST_BYTE;
            int_enable           <= tcrt_pkg::TCRT_RST_BYTE;
        end else if (reg_wr) begin
            if (reg_addr == tcrt_pkg::TCRT_ADDR_BASIC_MODE) begin
                basic_timer_mode_reg <= reg_wdata;
            end
            if (reg_addr == tcrt_pkg::TCRT_ADDR_INT_EN) begin
                int_enable <= reg_wdata;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BASIC; gi++) begin : g_basic
            localparam int RUN_BIT  = tcrt_pkg::TCRT_CTRL_RUN0 + 2 * gi;
            localparam int FLAG_BIT = tcrt_pkg::TCRT_CTRL_FLAG0 + 2 * gi;
            localparam int MB       = tcrt_pkg::TCRT_MODE_STRIDE * gi;
            localparam logic [3:0] A_LOW  = tcrt_pkg::TCRT_ADDR_CNT0_LOW + 4'(2 * gi);
            localparam logic [3:0] A_HIGH = tcrt_pkg::TCRT_ADDR_CNT0_HIGH + 4'(2 * gi);
            tcrt_pkg::tcrt_mode_e mode;
            logic run_ok;
            logic low_max;
            logic wr_low;
            logic wr_high;

            assign mode = tcrt_pkg::tcrt_mode_e'(basic_timer_mode_reg[MB + tcrt_pkg::TCRT_MODE_M_LSB +: 2]);
            assign run_ok = basic_timer_control[RUN_BIT]
                          & (~basic_timer_mode_reg[MB + tcrt_pkg::TCRT_MODE_GATE]
                             | ~ext_irq_input_n[gi]) & basic_tick;
            assign low_max = (count_low_reg[gi] == tcrt_pkg::TCRT_BYTE_MAX);
            assign wr_low  = reg_wr & (reg_addr == A_LOW);
            assign wr_high = reg_wr & (reg_addr == A_HIGH);

            // wrap decoded before the edge so the flag sets on the same edge as the count
            always_comb begin
                case (mode)
                    tcrt_pkg::TCRT_MODE_13BIT: begin
                        basic_ovf[gi] = run_ok & (count_low_reg[gi][4:0] == 5'h1F)
                                      & (count_high_reload_reg[gi] == tcrt_pkg::TCRT_BYTE_MAX);
                    end
                    tcrt_pkg::TCRT_MODE_16BIT: begin
                        basic_ovf[gi] = run_ok & low_max
                                      & (count_high_reload_reg[gi] == tcrt_pkg::TCRT_BYTE_MAX);
                    end
                    tcrt_pkg::TCRT_MODE_RELOAD: begin
                        basic_ovf[gi] = run_ok & low_max;
                    end
                    default: begin
                        basic_ovf[gi] = 1'b0;
                    end
                endcase
            end

            // low count: software write wins over counting
            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    count_low_reg[gi] <= tcrt_pkg::TCRT_RST_BYTE;
                end else if (wr_low) begin
                    count_low_reg[gi] <= reg_wdata;
                end else if (run_ok) begin
                    case (mode)
                        tcrt_pkg::TCRT_MODE_13BIT: begin
                            count_low_reg[gi] <= {3'h0, 5'(count_low_reg[gi][4:0] + 5'h01)};
                        end
                        tcrt_pkg::TCRT_MODE_16BIT: begin
                            count_low_reg[gi] <= count_low_reg[gi] + 8'h01;
                        end
                        tcrt_pkg::TCRT_MODE_RELOAD: begin
                            count_low_reg[gi] <= low_max ? count_high_reload_reg[gi]
                                                         : count_low_reg[gi] + 8'h01;
                        end
                        default: begin
                            count_low_reg[gi] <= count_low_reg[gi];
                        end
                    endcase
                end
            end

            // high byte is only a count in modes 0/1; in reload mode it is held
            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    count_high_reload_reg[gi] <= tcrt_pkg::TCRT_RST_BYTE;
                end else if (wr_high) begin
                    count_high_reload_reg[gi] <= reg_wdata;
                end else if (run_ok) begin
                    case (mode)
                        tcrt_pkg::TCRT_MODE_13BIT: begin
                            if (count_low_reg[gi][4:0] == 5'h1F) begin
                                count_high_reload_reg[gi] <= count_high_reload_reg[gi] + 8'h01;
                            end
                        end
                        tcrt_pkg::TCRT_MODE_16BIT: begin
                            if (low_max) begin
                                count_high_reload_reg[gi] <= count_high_reload_reg[gi] + 8'h01;
                            end
                        end
                        default: begin
                            count_high_reload_reg[gi] <= count_high_reload_reg[gi];
                        end
                    endcase
                end
            end

            // flag: an overflow in the clearing cycle still sets it
            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    overflow_flag[gi] <= 1'b0;
                end else if (basic_ovf[gi]) begin
                    overflow_flag[gi] <= 1'b1;
                end else if (reg_wr && reg_addr == tcrt_pkg::TCRT_ADDR_BASIC_CTRL) begin
                    overflow_flag[gi] <= reg_wdata[FLAG_BIT];
                end
            end

            assign timer_irq[gi] = overflow_flag[gi] & int_enable[gi];
        end
    endgenerate

    // run bits and low nibble held; flag bits live in overflow_flag
    logic [7:0] ctrl_store;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrl_store <= tcrt_pkg::TCRT_RST_BYTE;
        end else if (reg_wr && reg_addr == tcrt_pkg::TCRT_ADDR_BASIC_CTRL) begin
            ctrl_store <= reg_wdata;
        end
    end

    always_comb begin
        basic_timer_control = ctrl_store;
        basic_timer_control[tcrt_pkg::TCRT_CTRL_FLAG0] = overflow_flag[0];
        basic_timer_control[tcrt_pkg::TCRT_CTRL_FLAG1] = overflow_flag[1];
    end

    generate
        for (gi = 0; gi < NUM_ENH; gi++) begin : g_enh
            // four registers per timer; the low address bits pick one
            localparam logic [3:0] BASE = tcrt_pkg::TCRT_ADDR_ENH_BASE + 4'(4 * gi);
            tcrt_pkg::tcrt_enh_cfg_s cfg;
            logic sel;

            assign sel = reg_wr & (reg_addr[3:2] == BASE[3:2]);

            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    enhanced_timer_control[gi] <= tcrt_pkg::TCRT_RST_BYTE;
                    enhanced_timer_config[gi]  <= tcrt_pkg::TCRT_RST_BYTE;
                    reload_pair_low[gi]        <= tcrt_pkg::TCRT_RST_BYTE;
                    reload_pair_high[gi]       <= tcrt_pkg::TCRT_RST_BYTE;
                end else if (sel) begin
                    case (reg_addr[1:0])
                        tcrt_pkg::TCRT_ENH_OFS_CTRL: begin
                            enhanced_timer_control[gi] <= reg_wdata;
                        end
                        tcrt_pkg::TCRT_ENH_OFS_CFG: begin
                            enhanced_timer_config[gi] <= reg_wdata;
                        end
                        tcrt_pkg::TCRT_ENH_OFS_RLD_LOW: begin
                            reload_pair_low[gi] <= reg_wdata;
                        end
                        default: begin
                            reload_pair_high[gi] <= reg_wdata;
                        end
                    endcase
                end
            end

            assign cfg.capsel     = enhanced_timer_control[gi][tcrt_pkg::TCRT_ECTL_CAPSEL];
            assign cfg.ctsel      = enhanced_timer_control[gi][tcrt_pkg::TCRT_ECTL_CTSEL];
            assign cfg.run        = enhanced_timer_control[gi][tcrt_pkg::TCRT_ECTL_RUN];
            assign cfg.down       = enhanced_timer_control[gi][tcrt_pkg::TCRT_ECTL_DOWN];
            assign cfg.oe         = enhanced_timer_config[gi][tcrt_pkg::TCRT_ECFG_OE];
            assign cfg.level_wr   = sel & (reg_addr[1:0] == tcrt_pkg::TCRT_ENH_OFS_CFG);
            assign cfg.level_data = reg_wdata;

            tcrt_enh_timer #(
                .WIDTH(16)
            ) u_enh (
                .sys_clk      (sys_clk),
                .nrst         (nrst),
                .tick         (enh_tick),
                .cfg          (cfg),
                .reload_val   ({reload_pair_high[gi], reload_pair_low[gi]}),
                .count        (),
                .wrap         (),
                .toggle_level (enh_level[gi]),
                .pin_out      (enh_pin[gi]),
                .pin_oe_n     (enh_pin_oe_n[gi])
            );
        end
    endgenerate

    // enable follows the config bit even while the timer is stopped
    assign toggle_pin_a      = enh_pin[0];
    assign toggle_pin_a_oe_n = enh_pin_oe_n[0];
    assign toggle_pin_b      = enh_pin[1];
    assign toggle_pin_b_oe_n = enh_pin_oe_n[1];

    // read mux; count words of enhanced timers at 0x0 page is not mapped
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr)
            tcrt_pkg::TCRT_ADDR_BASIC_CTRL: begin
                next_rdata = basic_timer_control;
            end
            tcrt_pkg::TCRT_ADDR_BASIC_MODE: begin
                next_rdata = basic_timer_mode_reg;
            end
            tcrt_pkg::TCRT_ADDR_CNT0_LOW: begin
                next_rdata = count_low_reg[0];
            end
            tcrt_pkg::TCRT_ADDR_CNT0_HIGH: begin
                next_rdata = count_high_reload_reg[0];
            end
            tcrt_pkg::TCRT_ADDR_CNT1_LOW: begin
                next_rdata = count_low_reg[1];
            end
            tcrt_pkg::TCRT_ADDR_CNT1_HIGH: begin
                next_rdata = count_high_reload_reg[1];
            end
            tcrt_pkg::TCRT_ADDR_INT_EN: begin
                next_rdata = int_enable;
            end
            4'h8, 4'hC: next_rdata = enhanced_timer_control[reg_addr[2]];
            4'h9, 4'hD: begin
                next_rdata = enhanced_timer_config[reg_addr[2]];
                next_rdata[tcrt_pkg::TCRT_ECFG_TOGGLE] = enh_level[reg_addr[2]];
            end
            4'hA, 4'hE: next_rdata = reload_pair_low[reg_addr[2]];
            4'hB, 4'hF: next_rdata = reload_pair_high[reg_addr[2]];
            default:    next_rdata = 8'h00;
        endcase
    end

    // read data stand one cycle only; idle zero keeps the bus quiet
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// ===== bench/tcrt_top_asserts.sv
`timescale 1ns/100ps
// port-level view only: enhanced counts are not readable, so checks tie pins to their causes
module tcrt_top_asserts (
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       basic_tick,
    input wire logic       enh_tick,
    input wire logic [1:0] ext_irq_input_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] timer_irq,
    input wire logic       toggle_pin_a,
    input wire logic       toggle_pin_a_oe_n,
    input wire logic       toggle_pin_b,
    input wire logic       toggle_pin_b_oe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    AST_RDATA_ONE_CYCLE: assert property ($past(reg_rd) || reg_rdata == 8'h00)
        else $error("read data without a read");
    AST_OE_A: assert property (reg_wr && reg_addr == 4'h9 |=> toggle_pin_a_oe_n == !$past(reg_wdata[1]))
        else $error("pin a enable does not follow config");
    AST_PIN_A_GATED: assert property (toggle_pin_a_oe_n |-> !toggle_pin_a)
        else $error("pin a high while not enabled");
    AST_PIN_B_GATED: assert property (toggle_pin_b_oe_n |-> !toggle_pin_b)
        else $error("pin b high while not enabled");
    AST_FORCE_A: assert property (reg_wr && reg_addr == 4'h9 |=>
        toggle_pin_a == ($past(reg_wdata[2]) && $past(reg_wdata[1])))
        else $error("pin a not forced to written level");
    AST_FORCE_B: assert property (reg_wr && reg_addr == 4'hD |=>
        toggle_pin_b == ($past(reg_wdata[2]) && $past(reg_wdata[1])) && toggle_pin_b_oe_n == !$past(reg_wdata[1]))
        else $error("pin b not forced to written level");
    AST_TOGGLE_CAUSE: assert property ($changed(toggle_pin_a) && !toggle_pin_a_oe_n &&
        !$past(toggle_pin_a_oe_n) |-> $past(enh_tick) || $past(reg_wr))
        else $error("pin a toggled without a step");
    AST_IRQ0_CAUSE: assert property ($rose(timer_irq[0]) |-> $past(basic_tick) || $past(reg_wr))
        else $error("irq 0 raised without a step");
    AST_IRQ1_CAUSE: assert property ($rose(timer_irq[1]) |-> $past(basic_tick) || $past(reg_wr))
        else $error("irq 1 raised without a step");
    AST_IRQ_MASK: assert property (reg_wr && reg_addr == 4'h6 |=> (timer_irq & ~$past(reg_wdata[1:0])) == 2'b00)
        else $error("masked irq still raised");
endmodule

// ===== bench/tb_tcrt_top.sv
`timescale 1ns/100ps
module tb_tcrt_top;
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] n;
        logic [7:0] exp_lo;
        logic [7:0] exp_hi;
        logic       flag;
    } tcrt_tb_row_s;

    logic         sys_clk;
    logic         nrst;
    logic         basic_tick;
    logic         enh_tick;
    logic [1:0]   ext_irq_input_n;
    logic [3:0]   reg_addr;
    logic [7:0]   reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    logic [7:0]   reg_rdata;
    logic [1:0]   timer_irq;
    logic         toggle_pin_a;
    logic         toggle_pin_a_oe_n;
    logic         toggle_pin_b;
    logic         toggle_pin_b_oe_n;
    logic [1:0]   pins;
    logic [1:0]   pins_oe_n;
    logic [3:0]   b;
    int           err_count;
    int           tests_run;
    int           cycles;
    tcrt_tb_row_s rows [9];

    assign pins      = {toggle_pin_b, toggle_pin_a};
    assign pins_oe_n = {toggle_pin_b_oe_n, toggle_pin_a_oe_n};

    tcrt_top i_dut (.sys_clk(sys_clk), .nrst(nrst), .basic_tick(basic_tick), .enh_tick(enh_tick),
        .ext_irq_input_n(ext_irq_input_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_irq(timer_irq), .toggle_pin_a(toggle_pin_a),
        .toggle_pin_a_oe_n(toggle_pin_a_oe_n), .toggle_pin_b(toggle_pin_b), .toggle_pin_b_oe_n(toggle_pin_b_oe_n));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // a hang shows up as a mismatch rather than a silent stall
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            err_count = err_count + 1;
            summarize();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // one strobe cycle, then a quiet cycle so no signal is driven twice at one edge
    task automatic cyc(input logic w, input logic r, input logic bt, input logic et,
                       input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr     <= w;
        reg_rd     <= r;
        basic_tick <= bt;
        enh_tick   <= et;
        reg_addr   <= a;
        reg_wdata  <= d;
        @(posedge sys_clk);
        reg_wr     <= 1'b0;
        reg_rd     <= 1'b0;
        basic_tick <= 1'b0;
        enh_tick   <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, 1'b0, 1'b0, a, d);
    endtask

    task automatic rd(input logic [3:0] a);
        cyc(1'b0, 1'b1, 1'b0, 1'b0, a, 8'h00);
    endtask

    task automatic btick(input int k);
        repeat (k) cyc(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 8'h00);
    endtask

    task automatic epin(input int n, input int k, input logic exp);
        repeat (k) cyc(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 8'h00);
        chk({7'h00, pins[n]}, {7'h00, exp});
    endtask

    // level read back through the config register, pin may be disabled
    task automatic elvl(input int k, input logic exp);
        repeat (k) cyc(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 8'h00);
        rd(b + 4'h1);
        chk({7'h00, reg_rdata[2]}, {7'h00, exp});
    endtask

    initial begin
        nrst            = 1'b0;
        basic_tick      = 1'b0;
        enh_tick        = 1'b0;
        ext_irq_input_n = 2'b11;
        reg_addr        = 4'h0;
        reg_wdata       = 8'h00;
        reg_wr          = 1'b0;
        reg_rd          = 1'b0;
        b               = 4'h8;
        err_count       = 0;
        tests_run       = 0;
        cycles          = 0;
        rows = '{'{8'h02, 8'hFE, 8'hFE, 8'h01, 8'hFF, 8'hFE, 1'b0},
                 '{8'h02, 8'hFE, 8'hFE, 8'h02, 8'hFE, 8'hFE, 1'b1},
                 '{8'h02, 8'h10, 8'hFE, 8'h03, 8'h11, 8'h10, 1'b1},
                 '{8'h02, 8'h00, 8'hFF, 8'h02, 8'h01, 8'h00, 1'b1},
                 '{8'h01, 8'h00, 8'hFF, 8'h01, 8'h00, 8'h01, 1'b0},
                 '{8'h01, 8'hFF, 8'hFE, 8'h02, 8'h00, 8'h00, 1'b1},
                 '{8'h01, 8'hFF, 8'hFF, 8'h03, 8'h02, 8'h00, 1'b1},
                 '{8'h00, 8'h00, 8'h1F, 8'h01, 8'h00, 8'h01, 1'b0},
                 '{8'h03, 8'h12, 8'h34, 8'h02, 8'h34, 8'h12, 1'b0}};
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        chk({2'b00, timer_irq, pins, pins_oe_n}, 8'h03);
        rd(4'h0);
        chk(reg_rdata, 8'h00);
        rd(4'h1);
        chk(reg_rdata, 8'h00);
        $display("reset test done");

        wr(4'h6, 8'h03);
        for (int t = 0; t < 2; t++) begin
            foreach (rows[i]) begin
                wr(4'h0, 8'h00);
                wr(4'h1, rows[i].mode << (4 * t));
                wr(4'(3 + 2 * t), rows[i].hi);
                wr(4'(2 + 2 * t), rows[i].lo);
                wr(4'h0, 8'h10 << (2 * t));
                btick(int'(rows[i].n));
                rd(4'(2 + 2 * t));
                chk(reg_rdata, rows[i].exp_lo);
                rd(4'(3 + 2 * t));
                chk(reg_rdata, rows[i].exp_hi);
                rd(4'h0);
                chk(reg_rdata, {2'b00, rows[i].flag, 1'b1, 4'h0} << (2 * t));
                chk({6'h00, timer_irq}, 8'(rows[i].flag) << t);
            end
        end
        $display("row tests done");

        wr(4'h0, 8'h00);
        wr(4'h1, 8'h0A);
        wr(4'h2, 8'h00);
        wr(4'h0, 8'h10);
        btick(2);
        rd(4'h2);
        chk(reg_rdata, 8'h00);
        @(posedge sys_clk) ext_irq_input_n <= 2'b10;
        btick(2);
        rd(4'h2);
        chk(reg_rdata, 8'h02);
        wr(4'h0, 8'h00);
        btick(1);
        rd(4'h2);
        chk(reg_rdata, 8'h02);
        wr(4'h1, 8'h02);
        wr(4'h0, 8'h10);
        @(posedge sys_clk) ext_irq_input_n <= 2'b11;
        btick(1);
        rd(4'h2);
        chk(reg_rdata, 8'h03);
        wr(4'h0, 8'hA0);
        chk({6'h00, timer_irq}, 8'h03);
        wr(4'h6, 8'h00);
        chk({6'h00, timer_irq}, 8'h00);
        $display("gate and interrupt tests done");

        for (int n = 0; n < 2; n++) begin
            b = 4'h8 + 4'(4 * n);
            wr(b + 4'h1, 8'h02);
            wr(b + 4'h2, 8'hFC);
            wr(b + 4'h3, 8'hFF);
            wr(b, 8'h0C);
            epin(n, 1, 1'b0);
            epin(n, 3, 1'b0);
            epin(n, 1, 1'b1);
            epin(n, 3, 1'b1);
            epin(n, 1, 1'b0);
            rd(b + 4'h1);
            chk({6'h00, reg_rdata[2:1]}, 8'h01);
            wr(b, 8'h04);
            epin(n, 1, 1'b1);
            epin(n, 3, 1'b1);
            epin(n, 1, 1'b0);
            wr(b + 4'h1, 8'h06);
            chk({6'h00, pins[n], pins_oe_n[n]}, 8'h02);
            wr(b + 4'h1, 8'h04);
            chk({6'h00, pins[n], pins_oe_n[n]}, 8'h01);
            elvl(4, 1'b0);
            wr(b, 8'h05);
            elvl(4, 1'b0);
            wr(b, 8'h00);
            elvl(4, 1'b0);
            wr(b, 8'h04);
            elvl(4, 1'b1);
            wr(b, 8'h00);
            $display("toggle test done for timer %0d", n);
        end
        summarize();
    end
endmodule

bind tcrt_top tcrt_top_asserts i_chk (.sys_clk(sys_clk), .nrst(nrst), .basic_tick(basic_tick),
    .enh_tick(enh_tick), .ext_irq_input_n(ext_irq_input_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_irq(timer_irq),
    .toggle_pin_a(toggle_pin_a), .toggle_pin_a_oe_n(toggle_pin_a_oe_n), .toggle_pin_b(toggle_pin_b),
    .toggle_pin_b_oe_n(toggle_pin_b_oe_n));
